// ===== rtl/qsm_pkg.sv
// Package for the quad serial master transfer-control block.
// Assumes a 32-bit APB register bus and a single-lane receive link.
package qsm_pkg;

  // Register byte offsets
  localparam logic [11:0] QSM_OFF_MODE = 12'h000;
  localparam logic [11:0] QSM_OFF_CTRL = 12'h004;
  localparam logic [11:0] QSM_OFF_EXEC = 12'h008;
  localparam logic [11:0] QSM_OFF_STAT = 12'h00C;
  localparam logic [11:0] QSM_OFF_RXD = 12'h010;
  localparam logic [11:0] QSM_OFF_DESC = 12'h040;
  localparam int QSM_DESC_NUM = 16;

  // Transfer control and mode field positions
  localparam int QSM_LEN_LSB = 17;
  localparam int QSM_LEN_MSB = 31;
  localparam int QSM_DESC_EN_BIT = 16;
  localparam int QSM_PTR_LSB = 12;
  localparam int QSM_PTR_MSB = 15;
  localparam int QSM_UNITS_LSB = 10;
  localparam int QSM_UNITS_MSB = 11;
  localparam int QSM_CLOSE_BIT = 9;
  localparam int QSM_RXDMA_LSB = 7;
  localparam int QSM_RXDMA_MSB = 8;
  localparam int QSM_RXEN_BIT = 6;
  localparam int QSM_IFM_LSB = 0;
  localparam int QSM_IFM_MSB = 1;
  localparam int QSM_LOCAL_RX_BIT = 3;

  // Execute register bits
  localparam int QSM_EXEC_START = 0;
  localparam int QSM_EXEC_STOP = 1;
  localparam int QSM_EXEC_CLEAR = 2;

  // Reset values
  localparam logic [31:0] QSM_CTRL_RST = 32'h0000_0000;
  localparam logic QSM_MODE_RST = 1'b0;

  // Transfer unit codes
  localparam logic [1:0] QSM_UNIT_BIT = 2'h0;
  localparam logic [1:0] QSM_UNIT_BYTE = 2'h1;
  localparam logic [1:0] QSM_UNIT_SEG4 = 2'h2;
  localparam logic [1:0] QSM_UNIT_SEG16 = 2'h3;

  typedef enum logic [1:0] {
    QSM_IDLE = 2'b00,
    QSM_LOAD = 2'b01,
    QSM_SEND = 2'b11,
    QSM_WAIT = 2'b10
  } qsm_state_t;

  // Length in bits for a length field and its unit code
  function automatic logic [21:0] qsm_bits(input logic [14:0] len, input logic [1:0] units);
    case (units)
      QSM_UNIT_BIT: qsm_bits = {7'h00, len};
      QSM_UNIT_BYTE: qsm_bits = {4'h0, len, 3'h0};
      QSM_UNIT_SEG4: qsm_bits = {2'h0, len, 5'h00};
      default: qsm_bits = {len, 7'h00};
    endcase
  endfunction

endpackage

// ===== rtl/qsm_transfer_ctrl.sv
// Transfer control of the quad serial master: registers, descriptor
// sequencing, receive packing for DMA, and the link-side bit engine.
// Assumes spi_clk is the free-running link clock, gated outside by spi_clk_en, and miso is single-lane data.
// Notes on behaviour
// - The transfer length sits in control bits 31:17, counted in the chosen units.
// - A zero length runs the transfer until it is stopped or terminated by DMA.
// - Units code 3, 2, 1, 0 scale the length by 16 bytes, 4 bytes, a byte or a bit.
// - Bit 16 set runs the transfer from descriptors, clear uses the control register.
// - Descriptor runs begin at the descriptor indexed by bits 15:12.
// - With close set, chip select rises, the link idles and DMA is terminated at the end.
// - Centrally served, receive DMA code 1, 2, 3 is a 1, 2, 4 byte access and 0 is off.
// - Receive DMA is requested until the data is drained or DMA signals termination.
// - Locally served, the receive DMA field picks channel 1 to 3 and 0 disables it.
// - Receive enable bit 6 gates storing of received data.
// - Mode bit 3 chooses local or central receive DMA service.
module qsm_transfer_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_clk,
  input wire logic miso,
  output logic spi_cs_n,
  output logic spi_clk_en,
  output logic dma_req,
  output logic [1:0] dma_size,
  output logic [1:0] dma_channel,
  output logic dma_done,
  input wire logic dma_ack,
  input wire logic dma_term
);
  import qsm_pkg::*;

  logic [31:0] ctrl;
  logic local_rx;
  logic [31:0] desc [QSM_DESC_NUM];
  qsm_state_t state;
  logic [3:0] cur_desc;
  logic [21:0] seg_bits;
  logic seg_close, seg_last;
  logic req_tgl, abort, busy, done, overflow, term_seen, dma_stopped;
  logic ack_s1, ack_s2, ack_s3, byte_s1, byte_s2, byte_s3;
  logic [31:0] rx_word;
  logic [2:0] rx_cnt;
  logic rx_valid;
  logic lk_req_s1, lk_req_s2, lk_req_s3, lk_abort_s1, lk_abort_s2;
  logic miso_s1, miso_s2;
  logic lk_active, lk_ack_tgl, lk_byte_tgl;
  logic [21:0] lk_cnt;
  logic [1:0] lk_v, lk_e;
  logic [7:0] lk_sh, lk_byte;
  logic [2:0] lk_bitn;

  // APB decode
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd_pop = acc && !pwrite && paddr == QSM_OFF_RXD;
  wire is_desc = paddr >= QSM_OFF_DESC && paddr < QSM_OFF_DESC + 12'h040;
  wire [3:0] desc_idx = paddr[5:2];
  wire mapped = paddr[1:0] == 2'b00 && (is_desc || paddr <= QSM_OFF_RXD);
  wire ack_evt = ack_s2 ^ ack_s3;
  wire byte_evt = byte_s2 ^ byte_s3;
  wire exec_start = wr && paddr == QSM_OFF_EXEC && pwdata[QSM_EXEC_START];
  wire exec_stop = wr && paddr == QSM_OFF_EXEC && pwdata[QSM_EXEC_STOP];
  wire exec_clear = wr && paddr == QSM_OFF_EXEC && pwdata[QSM_EXEC_CLEAR];
  wire desc_en = ctrl[QSM_DESC_EN_BIT];
  wire rx_en = ctrl[QSM_RXEN_BIT];
  wire [1:0] rx_dma = ctrl[QSM_RXDMA_MSB:QSM_RXDMA_LSB];
  wire [31:0] src = desc_en ? desc[cur_desc] : ctrl;
  wire dma_pop = dma_ack && dma_req;
  wire pop = rd_pop || dma_pop;
  wire [2:0] need = (local_rx || rx_dma == 2'h0) ? 3'd1 : (rx_dma == 2'h3 ? 3'd4 : {1'b0, rx_dma});
  wire [2:0] base_cnt = pop ? 3'd0 : rx_cnt;
  wire xfer_end = state == QSM_WAIT && ack_evt && (seg_last || abort);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= 32'h0000_0000;
      if (setup && !pwrite) begin
        if (is_desc) begin
          prdata <= {desc[desc_idx][31:9], 9'h000};
        end else begin
          case (paddr)
            QSM_OFF_MODE: prdata <= {28'h0000000, local_rx, 3'h0};
            QSM_OFF_CTRL: prdata <= ctrl;
            QSM_OFF_STAT: prdata <= {24'h000000, cur_desc, term_seen, overflow, done, busy};
            QSM_OFF_RXD: prdata <= rx_word;
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Control, mode and descriptor registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= QSM_CTRL_RST;
      local_rx <= QSM_MODE_RST;
    end else if (wr) begin
      if (paddr == QSM_OFF_CTRL) begin
        ctrl <= {pwdata[31:6], 4'h0, pwdata[QSM_IFM_MSB:QSM_IFM_LSB]};
      end
      if (paddr == QSM_OFF_MODE) begin
        local_rx <= pwdata[QSM_LOCAL_RX_BIT];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && is_desc && paddr[1:0] == 2'b00) begin
      desc[desc_idx] <= pwdata;
    end
  end

  // Transfer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= QSM_IDLE;
      cur_desc <= 4'h0;
      seg_bits <= 22'h000000;
      {seg_close, seg_last} <= 2'b00;
      req_tgl <= 1'b0;
      abort <= 1'b0;
      busy <= 1'b0;
      dma_done <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      if ((exec_stop || dma_term) && busy) begin
        abort <= 1'b1;
      end
      case (state)
        QSM_IDLE: begin
          abort <= exec_stop && !exec_start;
          busy <= exec_start || exec_stop;
          if (exec_start) begin
            cur_desc <= ctrl[QSM_PTR_MSB:QSM_PTR_LSB];
            state <= QSM_LOAD;
          end else if (exec_stop) begin
            state <= QSM_SEND;
          end
        end
        QSM_LOAD: begin
          seg_bits <= qsm_bits(src[QSM_LEN_MSB:QSM_LEN_LSB], src[QSM_UNITS_MSB:QSM_UNITS_LSB]);
          seg_close <= src[QSM_CLOSE_BIT];
          seg_last <= src[QSM_CLOSE_BIT] || !desc_en;
          state <= QSM_SEND;
        end
        QSM_SEND: begin
          req_tgl <= !req_tgl;
          state <= QSM_WAIT;
        end
        QSM_WAIT: begin
          if (ack_evt) begin
            if (seg_last || abort) begin
              busy <= 1'b0;
              dma_done <= seg_close || abort;
              state <= QSM_IDLE;
            end else begin
              cur_desc <= cur_desc + 4'h1;
              state <= QSM_LOAD;
            end
          end
        end
        default: state <= QSM_IDLE;
      endcase
    end
  end

  // Sticky status; a new event wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      overflow <= 1'b0;
      term_seen <= 1'b0;
    end else begin
      if (xfer_end) begin
        done <= 1'b1;
      end else if (wr && paddr == QSM_OFF_STAT && pwdata[1]) begin
        done <= 1'b0;
      end
      if (byte_evt && rx_en && rx_valid && !pop) begin
        overflow <= 1'b1;
      end else if (wr && paddr == QSM_OFF_STAT && pwdata[2]) begin
        overflow <= 1'b0;
      end
      if (dma_term) begin
        term_seen <= 1'b1;
      end else if (wr && paddr == QSM_OFF_STAT && pwdata[3]) begin
        term_seen <= 1'b0;
      end
    end
  end

  // Receive packing to the DMA access size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word <= 32'h0000_0000;
      rx_cnt <= 3'd0;
      rx_valid <= 1'b0;
    end else if (exec_clear) begin
      rx_cnt <= 3'd0;
      rx_valid <= 1'b0;
    end else if (byte_evt && rx_en && !(rx_valid && !pop)) begin
      rx_word <= (base_cnt == 3'd0 ? '0 : rx_word) | 32'(lk_byte) << {base_cnt[1:0], 3'b000};
      rx_cnt <= base_cnt + 3'd1;
      rx_valid <= (base_cnt + 3'd1 == need) || xfer_end;
    end else if (pop) begin
      rx_cnt <= 3'd0;
      rx_valid <= 1'b0;
    end else if (xfer_end && rx_cnt != 3'd0) begin
      rx_valid <= 1'b1;
    end
  end

  // DMA request and access qualifiers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_stopped <= 1'b0;
      dma_req <= 1'b0;
      dma_size <= 2'h0;
      dma_channel <= 2'h0;
    end else begin
      if (dma_term) begin
        dma_stopped <= 1'b1;
      end else if (exec_start) begin
        dma_stopped <= 1'b0;
      end
      dma_req <= rx_valid && !pop && rx_dma != 2'h0 && !dma_stopped && !dma_term;
      dma_size <= local_rx ? 2'h0 : rx_dma;
      dma_channel <= local_rx ? rx_dma : 2'h0;
    end
  end

  // Crossings into the system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ack_s1, ack_s2, ack_s3} <= 3'b000;
      {byte_s1, byte_s2, byte_s3} <= 3'b000;
    end else begin
      {ack_s1, ack_s2, ack_s3} <= {lk_ack_tgl, ack_s1, ack_s2};
      {byte_s1, byte_s2, byte_s3} <= {lk_byte_tgl, byte_s1, byte_s2};
    end
  end

  // Link domain: request, abort and data synchronisers
  always_ff @(posedge spi_clk or negedge presetn) begin
    if (!presetn) begin
      {lk_req_s1, lk_req_s2, lk_req_s3} <= 3'b000;
      {lk_abort_s1, lk_abort_s2} <= 2'b00;
      {miso_s1, miso_s2} <= 2'b00;
    end else begin
      {lk_req_s1, lk_req_s2, lk_req_s3} <= {req_tgl, lk_req_s1, lk_req_s2};
      {lk_abort_s1, lk_abort_s2} <= {abort, lk_abort_s1};
      {miso_s1, miso_s2} <= {miso, miso_s1};
    end
  end

  wire lk_req_evt = lk_req_s2 ^ lk_req_s3;
  wire lk_last = seg_bits != 22'h000000 && lk_cnt + 22'h000001 == seg_bits;
  wire lk_stop = lk_active && (lk_abort_s2 || lk_last);

  // Bit engine; seg_bits and seg_close stay still while a request is out
  always_ff @(posedge spi_clk or negedge presetn) begin
    if (!presetn) begin
      lk_active <= 1'b0;
      lk_cnt <= 22'h000000;
      spi_cs_n <= 1'b1;
      spi_clk_en <= 1'b0;
    end else if (lk_req_evt) begin
      lk_active <= !lk_abort_s2;
      spi_clk_en <= !lk_abort_s2;
      spi_cs_n <= lk_abort_s2;
      lk_cnt <= 22'h000000;
    end else if (lk_stop) begin
      lk_active <= 1'b0;
      spi_clk_en <= 1'b0;
      spi_cs_n <= seg_close || lk_abort_s2;
    end else if (lk_active) begin
      lk_cnt <= lk_cnt + 22'h000001;
    end
  end

  // Sample pipeline matches the two-stage data synchroniser
  always_ff @(posedge spi_clk or negedge presetn) begin
    if (!presetn) begin
      lk_v <= 2'b00;
      lk_e <= 2'b00;
      lk_sh <= 8'h00;
      lk_byte <= 8'h00;
      lk_bitn <= 3'd0;
      lk_byte_tgl <= 1'b0;
      lk_ack_tgl <= 1'b0;
    end else begin
      lk_v <= {lk_v[0], lk_active && !lk_abort_s2};
      lk_e <= {lk_e[0], lk_stop || (lk_req_evt && lk_abort_s2)};
      if (lk_req_evt) begin
        lk_bitn <= 3'd0;
      end else if (lk_v[1]) begin
        lk_sh <= {lk_sh[6:0], miso_s2};
        lk_bitn <= lk_bitn + 3'd1;
        if (lk_bitn == 3'd7) begin
          lk_byte <= {lk_sh[6:0], miso_s2};
          lk_byte_tgl <= !lk_byte_tgl;
        end
      end
      if (lk_e[1]) begin
        lk_ack_tgl <= !lk_ack_tgl;
      end
    end
  end

  a_len_field: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == QSM_OFF_CTRL |=> ctrl[31:17] == $past(pwdata[31:17]))
    else $error("length field not stored");
  a_zero_len_runs: assert property (@(posedge spi_clk) disable iff (!presetn)
    lk_active && seg_bits == 22'h000000 && !lk_abort_s2 && !lk_req_evt |=> lk_active)
    else $error("zero length transfer ended");
  a_units_scale: assert property (@(posedge pclk) disable iff (!presetn)
    state == QSM_LOAD && !desc_en |=> seg_bits == qsm_bits(ctrl[31:17], ctrl[11:10]))
    else $error("length not scaled by units");
  a_no_desc_close: assert property (@(posedge pclk) disable iff (!presetn)
    state == QSM_LOAD && !desc_en |=> seg_last)
    else $error("single transfer not ended");
  a_desc_start: assert property (@(posedge pclk) disable iff (!presetn)
    state == QSM_IDLE && exec_start |=> cur_desc == $past(ctrl[15:12]) && state == QSM_LOAD)
    else $error("descriptor run began at wrong index");
  a_close_cs: assert property (@(posedge spi_clk) disable iff (!presetn)
    lk_stop && !lk_req_evt && seg_close |=> spi_cs_n && !spi_clk_en)
    else $error("chip select kept after closing end");
  a_open_cs: assert property (@(posedge spi_clk) disable iff (!presetn)
    lk_stop && !lk_req_evt && !seg_close && !lk_abort_s2 |=> !spi_cs_n)
    else $error("chip select dropped on open end");
  a_dma_off: assert property (@(posedge pclk) disable iff (!presetn)
    rx_dma == 2'h0 |=> !dma_req)
    else $error("dma requested while disabled");
  a_dma_size: assert property (@(posedge pclk) disable iff (!presetn)
    !local_rx ##1 !local_rx |-> dma_size == $past(rx_dma) && dma_channel == 2'h0)
    else $error("central access size wrong");
  a_dma_term: assert property (@(posedge pclk) disable iff (!presetn)
    dma_term |=> !dma_req [*2])
    else $error("dma requested after termination");
  a_local_chan: assert property (@(posedge pclk) disable iff (!presetn)
    local_rx ##1 local_rx |-> dma_channel == $past(rx_dma) && dma_size == 2'h0)
    else $error("local channel wrong");
  a_rx_gate: assert property (@(posedge pclk) disable iff (!presetn)
    byte_evt && !rx_en && !rx_valid |=> !rx_valid && $stable(rx_cnt))
    else $error("data stored with receive off");

endmodule // qsm_transfer_ctrl

// ===== verif/qsm_flash_model.sv
// Serial flash stand-in on the receive line of the quad serial master.
// Assumes data is wanted on spi_clk rising while spi_cs_n is low.
module qsm_flash_model (
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_clk_en,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  // Selected: answers all ones; deselected: line floats, so it toggles
  initial miso = 1'b0;
  always @(negedge spi_clk or negedge spi_cs_n) begin
    if (!spi_cs_n) miso <= 1'b1;
    else miso <= ~miso;
  end
endmodule // qsm_flash_model

// ===== verif/quad_spi_transfer_control_test.sv
// Self-checking bench of the quad serial master transfer control.
// Assumes the APB slave, the link clock and the flash stand-in above.
module quad_spi_transfer_control_test;
  import qsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, miso, spi_cs_n, spi_clk_en, dma_req, dma_done;
  logic spi_clk = 1'b0, dma_ack = 1'b0, dma_term = 1'b0;
  logic [1:0] dma_size, dma_channel;
  int errors = 0, comparisons = 0, bits = 0, dones = 0;

  always #5 pclk = ~pclk;
  initial begin
    #3;
    forever begin
      spi_clk = ~spi_clk;
      #80;
    end
  end
  always @(posedge spi_clk) if (spi_clk_en === 1'b1) bits <= bits + 1;
  always @(posedge pclk) if (dma_done === 1'b1) dones <= dones + 1;

  qsm_transfer_ctrl u_qsm_transfer_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_clk(spi_clk), .miso(miso), .spi_cs_n(spi_cs_n),
    .spi_clk_en(spi_clk_en), .dma_req(dma_req), .dma_size(dma_size),
    .dma_channel(dma_channel), .dma_done(dma_done), .dma_ack(dma_ack), .dma_term(dma_term));
  qsm_flash_model u_qsm_flash_model (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_clk_en(spi_clk_en), .miso(miso));

  task automatic fail(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail("bus hang");
      final_report();
    end
  endtask
  // Interface mode stays single, so rx enable never clashes with it
  function automatic logic [31:0] ctl(input logic [14:0] len, input logic de,
      input logic [3:0] p, input logic [1:0] u, input logic cl, input logic [1:0] rdm,
      input logic rx);
    return {len, de, p, u, cl, rdm, rx, 6'h00};
  endfunction
  task automatic wait_cs(input logic lvl);
    int n;
    for (n = 0; n < 300 && spi_cs_n !== lvl; n++) @(posedge pclk);
    chk(32'(spi_cs_n), 32'(lvl), "chip select level");
  endtask
  // A start is refused while busy, so scenarios wait for the sequencer to idle
  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, QSM_OFF_STAT, '0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 300) fail("busy never cleared");
  endtask
  // Runs one closing transfer while acting as the DMA controller
  task automatic xfer(input logic [31:0] c, input int eb, input int ea,
      input logic [1:0] esz, input logic [1:0] ech);
    int b0, d0, acks, k, i;
    b0 = bits;
    d0 = dones;
    acks = 0;
    k = 0;
    apb(1'b1, QSM_OFF_CTRL, c);
    apb(1'b1, QSM_OFF_EXEC, 32'h0000_0001);
    for (i = 0; i < 4000 && k < 100; i++) begin
      @(posedge pclk);
      if (dones != d0) k++;
      dma_ack <= dma_req === 1'b1 && !dma_ack;
      if (dma_req === 1'b1 && !dma_ack) begin
        acks++;
        chk(32'(dma_size), 32'(esz), "dma size");
        chk(32'(dma_channel), 32'(ech), "dma channel");
      end
    end
    if (k < 100) begin
      fail("transfer never ended");
      final_report();
    end
    chk(32'(bits - b0), 32'(eb), "bit count");
    chk(32'(acks), 32'(ea), "dma words");
    chk(32'(dones - d0), 32'h0000_0001, "dma terminate pulse");
    chk(32'(spi_cs_n), 32'h0000_0001, "chip select after close");
  endtask

  task automatic t_regs();
    apb(1'b0, QSM_OFF_CTRL, '0);
    chk(rd, QSM_CTRL_RST, "ctrl reset value");
    apb(1'b0, QSM_OFF_MODE, '0);
    chk(32'(rd[3]), 32'(QSM_MODE_RST), "mode reset value");
    chk(32'(spi_cs_n), 32'h0000_0001, "idle chip select");
    apb(1'b1, QSM_OFF_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, QSM_OFF_CTRL, '0);
    chk(rd, 32'hFFFF_FFC3, "ctrl fields");
    apb(1'b0, 12'h020, '0);
    chk(32'(er), 32'h0000_0001, "unmapped error");
    chk(rd, '0, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_units();
    int ln[4] = '{12, 2, 1, 1};
    int eb[4] = '{12, 16, 32, 128};
    for (int u = 0; u < 4; u++) xfer(ctl(15'(ln[u]), 1'b0, 4'h0, 2'(u), 1'b1, 2'h0, 1'b0),
      eb[u], 0, 2'h0, 2'h0);
    $display("test units done");
  endtask
  task automatic t_dma();
    int ea[4] = '{0, 4, 2, 1};
    apb(1'b1, QSM_OFF_MODE, '0);
    for (int c = 1; c < 4; c++) xfer(ctl(15'h0004, 1'b0, 4'h0, QSM_UNIT_BYTE, 1'b1, 2'(c),
      1'b1), 32, ea[c], 2'(c), 2'h0);
    apb(1'b1, QSM_OFF_MODE, 32'h0000_0008);
    xfer(ctl(15'h0002, 1'b0, 4'h0, QSM_UNIT_BYTE, 1'b1, 2'h2, 1'b1), 16, 2, 2'h0, 2'h2);
    xfer(ctl(15'h0002, 1'b0, 4'h0, QSM_UNIT_BYTE, 1'b1, 2'h0, 1'b1), 16, 0, 2'h0, 2'h0);
    apb(1'b0, QSM_OFF_STAT, '0);
    chk(32'(rd[3:1]), 32'h0000_0003, "done and overflow flags");
    apb(1'b1, QSM_OFF_STAT, 32'h0000_0006);
    apb(1'b1, QSM_OFF_EXEC, 32'h0000_0004);
    xfer(ctl(15'h0001, 1'b0, 4'h0, QSM_UNIT_BYTE, 1'b1, 2'h0, 1'b1), 8, 0, 2'h0, 2'h0);
    apb(1'b0, QSM_OFF_STAT, '0);
    chk(32'(rd[2:1]), 32'h0000_0001, "buffer cleared without overflow");
    apb(1'b0, QSM_OFF_RXD, '0);
    chk(rd, 32'h0000_00FF, "received byte");
    apb(1'b1, QSM_OFF_MODE, '0);
    $display("test dma done");
  endtask
  task automatic t_open();
    int b0, d0;
    b0 = bits;
    d0 = dones;
    apb(1'b1, QSM_OFF_CTRL, ctl(15'h0008, 1'b0, 4'h0, QSM_UNIT_BIT, 1'b0, 2'h0, 1'b0));
    apb(1'b1, QSM_OFF_EXEC, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    wait_idle();
    chk(32'(bits - b0), 32'h0000_0008, "open bit count");
    chk(32'(spi_cs_n), '0, "chip select held");
    chk(32'(dones - d0), '0, "no terminate when open");
    apb(1'b1, QSM_OFF_EXEC, 32'h0000_0002);
    wait_cs(1'b1);
    wait_idle();
    $display("test open done");
  endtask
  task automatic t_endless();
    int b0;
    b0 = bits;
    apb(1'b1, QSM_OFF_CTRL, ctl(15'h0000, 1'b0, 4'h0, QSM_UNIT_BYTE, 1'b1, 2'h0, 1'b0));
    apb(1'b1, QSM_OFF_EXEC, 32'h0000_0001);
    repeat (3200) @(posedge pclk);
    chk(32'(spi_cs_n), '0, "endless still selected");
    chk(32'(bits - b0 > 150), 32'h0000_0001, "endless keeps clocking");
    @(posedge pclk);
    dma_term <= 1'b1;
    @(posedge pclk);
    dma_term <= 1'b0;
    wait_cs(1'b1);
    wait_idle();
    $display("test endless done");
  endtask
  task automatic t_desc();
    // Close in the last descriptor and in the decoy one before the start, not in the first of the run
    apb(1'b1, QSM_OFF_DESC + 12'h010, ctl(15'h0028, 1'b0, 4'h0, 2'h0, 1'b1, 2'h0, 1'b0));
    apb(1'b1, QSM_OFF_DESC + 12'h014, ctl(15'h0008, 1'b0, 4'h0, 2'h0, 1'b0, 2'h0, 1'b0));
    apb(1'b1, QSM_OFF_DESC + 12'h018, ctl(15'h0010, 1'b0, 4'h0, 2'h0, 1'b1, 2'h0, 1'b0));
    xfer(ctl(15'h0000, 1'b1, 4'h5, 2'h0, 1'b0, 2'h0, 1'b0), 24, 0, 2'h0, 2'h0);
    $display("test descriptors done");
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_units();
    t_dma();
    t_open();
    t_endless();
    t_desc();
    final_report();
  end
  initial begin
    #1000000;
    fail("run timeout");
    final_report();
  end
endmodule // quad_spi_transfer_control_test
